// *** sim/link_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   output logic bc_clk,
   output logic bc_data,
   output logic bc_sync
);
   initial begin
      bc_clk = 1'b0;
      bc_data = 1'b0;
      bc_sync = 1'b0;
   end
   // One 30-bit frame, MSB first; clock stands low between frames
   task automatic send(input logic [3:0] pins, input logic st, input logic bad);
      logic [29:0] f;
      logic [7:0] c;
      f = {pins, st, 17'h0, 8'h00};
      c = 8'h00;
      // Leading zero bits of the CRC word leave a zero CRC unchanged
      for (int i = 21; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i + 8]) ? 8'h07 : 8'h00);
      end
      f[7:0] = bad ? ~c : c;
      #7;
      for (int i = 29; i >= 0; i--) begin
         bc_data = f[i];
         bc_sync = (i == 29);
         #100 bc_clk = 1'b1;
         #100 bc_clk = 1'b0;
      end
      bc_sync = 1'b0;
      // Line released: show the inverse so no stale bit passes for data
      bc_data = ~bc_data;
   endtask
endmodule // link_partner_model
`default_nettype wire

// *** sim/serializer_link_gpio_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module serializer_link_gpio_props (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] mode_strap,
   input wire logic sda_out,
   input wire serializer_link_gpio_pkg::fc_frame_t fc_frame,
   input wire logic fc_frame_valid
);
   import serializer_link_gpio_pkg::*;
   // Body as the sender built it, before any balancing inversion
   fc_body_t plain;
   assign plain = fc_frame.invert ? ~fc_frame.body : fc_frame.body;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   fc_cadence_a: assert property (fc_frame_valid |=> !fc_frame_valid [*3] ##1 fc_frame_valid)
      else $error("forward frame cadence broken");
   fc_sync_a: assert property (fc_frame_valid |-> fc_frame.sync == FC_SYNC_WORD)
      else $error("forward frame sync word wrong");
   fc_balance_a: assert property (fc_frame_valid |-> $countones(fc_frame.body) <= 18)
      else $error("forward frame not balanced");
   fc_hold_a: assert property (!fc_frame_valid |-> $stable(fc_frame))
      else $error("forward frame changed between pulses");
   pin_count_a: assert property (fc_frame_valid |-> plain.pin_count <= 3'h4)
      else $error("forwarded pin count above four");
   pin_mask_a: assert property (fc_frame_valid |-> (plain.pin_data >> plain.pin_count) == 4'h0)
      else $error("pin beyond count forwarded");
   payload_idle_a: assert property (fc_frame_valid && !plain.self_test |-> plain.payload == 21'h0)
      else $error("payload not idle outside self test");
   test_mode_a: assert property (fc_frame_valid && plain.self_test |-> mode_strap == 2'h0)
      else $error("self test outside synchronous mode");
   sda_low_a: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
endmodule // serializer_link_gpio_props
bind serializer_link_gpio serializer_link_gpio_props props_i (.clk, .rst_b, .mode_strap, .sda_out, .fc_frame,
   .fc_frame_valid);
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import serializer_link_gpio_pkg::*;
   logic clk, rst_b, scl_in, m_sda, sda_out, sda_oe_b, fc_frame_valid, bc_clk, bc_data, bc_sync;
   logic [3:0] ext, gpio_out, gpio_oe_b, gpio_pulldown;
   logic [8:0] r;
   logic [1:0] mode;
   fc_frame_t fc_frame;
   fc_body_t fb;
   wire logic sda_in;
   wire logic [3:0] gpio_in;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   assign sda_in = m_sda & (sda_oe_b | sda_out);
   assign gpio_in = (gpio_oe_b & ext) | (~gpio_oe_b & gpio_out);
   assign fb = fc_frame.invert ? ~fc_frame.body : fc_frame.body;
   serializer_link_gpio serializer_link_gpio_i (.clk, .rst_b, .mode_strap(mode), .scl_in, .sda_in, .sda_out,
      .sda_oe_b, .gpio_in, .gpio_out, .gpio_oe_b, .gpio_pulldown, .bc_clk, .bc_data, .bc_sync, .fc_frame,
      .fc_frame_valid);
   link_partner_model link_partner_model_i (.bc_clk, .bc_data, .bc_sync);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Run needs about 17k cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // Five cycles a phase keeps each bus clock phase above 100 ns
   task automatic q(input logic c, input logic s);
      scl_in <= c;
      m_sda <= s;
      repeat (5) @(posedge clk);
   endtask
   task automatic io(input logic [8:0] v, output logic [8:0] o);
      for (int i = 8; i >= 0; i--) begin
         q(1'b0, m_sda);
         q(1'b0, v[i]);
         q(1'b1, v[i]);
         o[i] = sda_in;
      end
   endtask
   task automatic start();
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
      q(1'b1, 1'b0);
      q(1'b0, 1'b0);
   endtask
   task automatic stop();
      q(1'b0, 1'b0);
      q(1'b1, 1'b0);
      q(1'b1, 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] b[3];
      b = '{{DEVICE_ADDR, 1'b0}, a, v};
      start();
      foreach (b[i]) begin
         io({b[i], 1'b1}, r);
         chk(r[0], 1'b0);
      end
      stop();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      start();
      io({DEVICE_ADDR, 1'b0, 1'b1}, r);
      chk(r[0], 1'b0);
      io({a, 1'b1}, r);
      chk(r[0], 1'b0);
      start();
      io({DEVICE_ADDR, 1'b1, 1'b1}, r);
      chk(r[0], 1'b0);
      io(9'h1FF, r);
      chk(r[8:1] & m, e);
      stop();
   endtask
   task automatic wait_out(input logic [3:0] e, input int lim);
      for (int i = 0; i < lim && gpio_out !== e; i++) @(posedge clk);
      chk(gpio_out, e);
   endtask
   // Spread of input-to-frame delay over all start phases is one frame less than the sample period
   task automatic fwd(input logic [2:0] n, input int p);
      int lo, hi, k;
      lo = 99;
      hi = 0;
      wr(REG_FWD_CFG, {5'h0, n});
      for (int ph = 0; ph < p; ph++) begin
         ext <= 4'hF;
         repeat (2 * p + 2 + ph) @(posedge clk iff fc_frame_valid);
         chk(fb.pin_data, 4'hF >> (3'h4 - n));
         chk(fb.pin_count, n);
         ext <= 4'h0;
         k = 0;
         do begin
            @(posedge clk iff fc_frame_valid);
            k++;
         end while (fb.pin_data !== 4'h0 && k < 12);
         if (k < lo) lo = k;
         if (k > hi) hi = k;
      end
      chk(hi - lo, p - 1);
   endtask
   initial begin
      rst_b = 1'b0;
      mode = 2'h0;
      scl_in = 1'b1;
      m_sda = 1'b1;
      ext = 4'h5;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      chk(gpio_pulldown, 4'hF);
      chk(gpio_oe_b, 4'hF);
      rd(REG_PIN_DIR, 8'h0F, 8'hFF);
      rd(REG_LOCAL_OUT, 8'h00, 8'hFF);
      rd(REG_FWD_CFG, 8'h00, 8'hFF);
      rd(8'h20, 8'h00, 8'hFF);
      rd(REG_PIN_STS, 8'h05, 8'hFF);
      start();
      io({DEVICE_ADDR ^ 7'h01, 1'b0, 1'b1}, r);
      chk(r[0], 1'b1);
      stop();
      $display("reset test done");
      ext <= 4'hA;
      wr(REG_PIN_DIR, 8'h03);
      chk(gpio_pulldown, 4'h3);
      rd(REG_PIN_STS, 8'h02, 8'hFF);
      wr(REG_PIN_STS, 8'hFF);
      rd(REG_PIN_STS, 8'h02, 8'hFF);
      $display("status test done");
      wr(REG_PIN_DIR, 8'h0F);
      fwd(3'h1, 1);
      fwd(3'h2, 2);
      fwd(3'h3, 5);
      fwd(3'h4, 5);
      $display("forward test done");
      wr(REG_PIN_DIR, 8'hF5);
      chk(gpio_oe_b, 4'h0);
      chk(gpio_pulldown, 4'h5);
      wr(REG_LOCAL_OUT, 8'h06);
      wait_out(4'h6, 4);
      rd(REG_PIN_STS, 8'h04, 8'hFF);
      wr(REG_LOCAL_OUT, 8'hF0);
      link_partner_model_i.send(4'hA, 1'b0, 1'b0);
      wait_out(4'hA, 30);
      link_partner_model_i.send(4'h5, 1'b0, 1'b1);
      repeat (30) @(posedge clk);
      chk(gpio_out, 4'hA);
      link_partner_model_i.send(4'hB, 1'b0, 1'b0);
      wait_out(4'hB, 30);
      link_partner_model_i.send(4'hA, 1'b0, 1'b0);
      wait_out(4'hA, 30);
      $display("remote test done");
      link_partner_model_i.send(4'hA, 1'b1, 1'b0);
      repeat (40) @(posedge clk);
      chk(fb.self_test, 1'b1);
      chk(|fb.payload, 1'b1);
      rd(REG_ST_ERR_CNT, 8'h00, 8'hFF);
      link_partner_model_i.send(4'hA, 1'b1, 1'b1);
      link_partner_model_i.send(4'hA, 1'b1, 1'b1);
      rd(REG_LINK_STS, 8'h08, 8'h08);
      rd(REG_ST_ERR_CNT, 8'h02, 8'hFF);
      wr(REG_ERR_CLEAR, 8'h20);
      rd(REG_ST_ERR_CNT, 8'h00, 8'hFF);
      rd(REG_LINK_STS, 8'h00, 8'h08);
      link_partner_model_i.send(4'hA, 1'b0, 1'b0);
      repeat (40) @(posedge clk);
      chk(fb.self_test, 1'b0);
      chk(fb.payload, 21'h0);
      $display("self test done");
      // Strap is caught only at reset release, so a second reset brings in the slower mode
      mode <= 2'h1;
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      chk(gpio_pulldown, 4'hF);
      wr(REG_PIN_DIR, 8'hF0);
      wr(REG_LOCAL_OUT, 8'hF0);
      link_partner_model_i.send(4'h9, 1'b1, 1'b0);
      wait_out(4'h9, 130);
      repeat (40) @(posedge clk);
      chk(fb.self_test, 1'b0);
      $display("mode test done");
      conclude();
   end
endmodule // testbench
`default_nettype wire

// *** verilog/serializer_link_gpio.sv ***
// Summary of operation
// - Four pins, register monitored and controlled
// - Status register returns each pin level
// - Status valid only with input enable
// - Input enable connects pin pull-down
// - All pins inputs after reset
// - Input enables in direction bits 3:0
// - Output enables in direction bits 7:4
// - Count field sets forwarded pin number
// - Up to four pins forwarded
// - Sample every 1, 2 or 5 frames
// - Output may drive remote back-channel value
// - Back-channel sample rate follows clocking mode
// - Self-test sends continuous pseudo-random payload
// - Self-test checks every back-channel frame CRC
// - Remote-driven output reproduces frame sync
// - Frame sync skew about one frame
// - Back-channel frames 30 bits, separate clock and sync lines
// - Forward frames 40 bits, DC balanced
// - Self-test error flag and error counter
`timescale 1ns/1ps
`default_nettype none
module serializer_link_gpio (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [1:0] mode_strap,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe_b,
   output logic [3:0] gpio_pulldown,
   input wire logic bc_clk,
   input wire logic bc_data,
   input wire logic bc_sync,
   output serializer_link_gpio_pkg::fc_frame_t fc_frame,
   output logic fc_frame_valid
);
   import serializer_link_gpio_pkg::*;

   typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_REG, BUS_WDATA, BUS_RDATA} bus_state_t;

   logic [7:0] local_pin_output_data;
   logic [7:0] pin_direction_control;
   logic [7:0] forwarded_pin_config;
   logic [7:0] self_test_error_count;
   logic self_test_err;
   logic [3:0] gpio_m, gpio_s;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic bclk_m, bclk_s, bclk_d, bdat_m, bdat_s, bsync_m, bsync_s;
   logic strap_taken;
   clk_mode_t clk_mode;
   bus_state_t bus_state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg, rd_byte, reg_ptr;
   logic do_ack, sda_drive_low, wr_en;
   logic [7:0] wr_addr, wr_data, rd_mux;
   logic [3:0] pin_level_status;
   logic [29:0] bc_shreg;
   logic [4:0] bc_cnt;
   bc_frame_t bc_rx;
   logic bc_done;
   logic [3:0] bc_latest_pins, remote_pins;
   logic self_test_req, self_test_active;
   logic [8:0] bc_sample_cnt, bc_sample_period;
   logic bc_sample_en;
   logic [3:0] fc_tick_cnt;
   logic fc_tick;
   logic [2:0] fc_mod_cnt, fc_period, pin_count;
   logic [3:0] fwd_mask, fwd_pins;
   logic [22:0] prbs;
   fc_body_t next_body;
   logic crc_ok, st_err_event, st_clear;

   function automatic logic [5:0] count_ones(input logic [36:0] v);
      logic [5:0] n;
      n = 6'd0;
      for (int i = 0; i < 37; i++) begin
         n = n + 6'(v[i]);
      end
      return n;
   endfunction

   // Synchronisers for every pin from outside the clock domain but the reset and the mode strap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gpio_m <= 4'h0;
         gpio_s <= 4'h0;
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         bclk_m <= 1'b0;
         bclk_s <= 1'b0;
         bclk_d <= 1'b0;
         bdat_m <= 1'b0;
         bdat_s <= 1'b0;
         bsync_m <= 1'b0;
         bsync_s <= 1'b0;
      end else begin
         gpio_m <= gpio_in;
         gpio_s <= gpio_m;
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         bclk_m <= bc_clk;
         bclk_s <= bclk_m;
         bclk_d <= bclk_s;
         bdat_m <= bc_data;
         bdat_s <= bdat_m;
         bsync_m <= bc_sync;
         bsync_s <= bsync_m;
      end
   end

   // Clocking mode strap caught once after reset release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_taken <= 1'b0;
         clk_mode <= MODE_SYNC;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         case (mode_strap)
            2'h0: clk_mode <= MODE_SYNC;
            2'h1: clk_mode <= MODE_NONSYNC;
            default: clk_mode <= MODE_PARALLEL;
         endcase
      end
   end

   // Control bus slave: address, register pointer, data with auto-increment
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state <= BUS_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         rd_byte <= 8'h00;
         reg_ptr <= 8'h00;
         do_ack <= 1'b0;
         sda_drive_low <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (scl_s && sda_d && !sda_s) begin
            bus_state <= BUS_ADDR;
            bit_cnt <= 4'h0;
            sda_drive_low <= 1'b0;
         end else if (scl_s && !sda_d && sda_s) begin
            bus_state <= BUS_IDLE;
            sda_drive_low <= 1'b0;
         end else if (bus_state != BUS_IDLE && scl_s && !scl_d) begin
            if (bit_cnt < 4'd7) begin
               shreg <= {shreg[6:0], sda_s};
               bit_cnt <= bit_cnt + 4'd1;
            end else if (bit_cnt == 4'd7) begin
               bit_cnt <= 4'd8;
               do_ack <= 1'b1;
               case (bus_state)
                  BUS_ADDR: begin
                     if (shreg[6:0] != DEVICE_ADDR) begin
                        bus_state <= BUS_IDLE;
                        do_ack <= 1'b0;
                     end else if (sda_s) begin
                        bus_state <= BUS_RDATA;
                     end else begin
                        bus_state <= BUS_REG;
                     end
                  end
                  BUS_REG: begin
                     reg_ptr <= {shreg[6:0], sda_s};
                     bus_state <= BUS_WDATA;
                  end
                  BUS_WDATA: begin
                     wr_en <= 1'b1;
                     wr_addr <= reg_ptr;
                     wr_data <= {shreg[6:0], sda_s};
                     reg_ptr <= reg_ptr + 8'd1;
                  end
                  BUS_RDATA: do_ack <= 1'b0;
                  default: bus_state <= BUS_IDLE;
               endcase
            end else begin
               bit_cnt <= 4'h0;
               if (bus_state == BUS_RDATA) begin
                  if (sda_s) begin
                     bus_state <= BUS_IDLE;
                  end else begin
                     rd_byte <= rd_mux;
                     reg_ptr <= reg_ptr + 8'd1;
                  end
               end
            end
         end else if (!scl_s && scl_d) begin
            if (bit_cnt == 4'd8) begin
               sda_drive_low <= do_ack;
            end else if (bus_state == BUS_RDATA) begin
               sda_drive_low <= ~rd_byte[3'(4'd7 - bit_cnt)];
            end else begin
               sda_drive_low <= 1'b0;
            end
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_b = ~sda_drive_low;

   // Status shows a pin only while its input enable is set
   assign pin_level_status = gpio_s & pin_direction_control[IN_EN_LSB +: NUM_PINS];

   always_comb begin
      case (reg_ptr)
         REG_LOCAL_OUT: rd_mux = local_pin_output_data;
         REG_PIN_DIR: rd_mux = pin_direction_control;
         REG_FWD_CFG: rd_mux = forwarded_pin_config;
         REG_LINK_STS: rd_mux = {4'h0, self_test_err, 3'h0};
         REG_PIN_STS: rd_mux = {4'h0, pin_level_status};
         REG_ST_ERR_CNT: rd_mux = self_test_error_count;
         default: rd_mux = 8'h00;
      endcase
   end

   // Writable registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         local_pin_output_data <= LOCAL_OUT_RESET;
         pin_direction_control <= PIN_DIR_RESET;
         forwarded_pin_config <= FWD_CFG_RESET;
      end else if (wr_en) begin
         case (wr_addr)
            REG_LOCAL_OUT: local_pin_output_data <= wr_data;
            REG_PIN_DIR: pin_direction_control <= wr_data;
            REG_FWD_CFG: forwarded_pin_config <= wr_data;
            default: ;
         endcase
      end
   end

   // Back-channel deserialiser: a high sync bit marks the first bit of a frame
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bc_shreg <= 30'h0;
         bc_cnt <= 5'd0;
         bc_rx <= '0;
         bc_done <= 1'b0;
      end else begin
         bc_done <= 1'b0;
         if (bclk_s && !bclk_d) begin
            bc_shreg <= {bc_shreg[28:0], bdat_s};
            if (bsync_s) begin
               bc_cnt <= 5'd1;
            end else if (bc_cnt == BC_LAST_BIT) begin
               bc_cnt <= 5'd0;
               bc_rx <= {bc_shreg[28:0], bdat_s};
               bc_done <= 1'b1;
            end else if (bc_cnt != 5'd0) begin
               bc_cnt <= bc_cnt + 5'd1;
            end
         end
      end
   end

   assign crc_ok = (crc8({10'h0, bc_rx.pin_data, bc_rx.self_test_en, bc_rx.control}) == bc_rx.crc);

   // Only frames with a good CRC update remote state; self-test runs in synchronous mode alone
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bc_latest_pins <= 4'h0;
         self_test_req <= 1'b0;
      end else if (bc_done && crc_ok) begin
         bc_latest_pins <= bc_rx.pin_data;
         self_test_req <= bc_rx.self_test_en;
      end
   end

   assign self_test_active = self_test_req && (clk_mode == MODE_SYNC);

   always_comb begin
      case (clk_mode)
         MODE_SYNC: bc_sample_period = BC_SAMPLE_SYNC_CYC;
         MODE_NONSYNC: bc_sample_period = BC_SAMPLE_NONSYNC_CYC;
         default: bc_sample_period = BC_SAMPLE_PARALLEL_CYC;
      endcase
   end

   // Remote pin values are resampled at the mode's rate
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bc_sample_cnt <= 9'd0;
         bc_sample_en <= 1'b0;
      end else begin
         bc_sample_en <= 1'b0;
         if (bc_sample_cnt >= bc_sample_period - 9'd1) begin
            bc_sample_cnt <= 9'd0;
            bc_sample_en <= 1'b1;
         end else begin
            bc_sample_cnt <= bc_sample_cnt + 9'd1;
         end
      end
   end

   // Synchronous-mode sampling keeps frame sync skew near one frame period
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         remote_pins <= 4'h0;
      end else if (bc_sample_en) begin
         remote_pins <= bc_latest_pins;
      end
   end

   // Pin drivers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gpio_out <= 4'h0;
         gpio_oe_b <= 4'hF;
         gpio_pulldown <= 4'h0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            gpio_out[i] <= local_pin_output_data[REMOTE_SEL_LSB + i] ? remote_pins[i] :
                           local_pin_output_data[LOCAL_VAL_LSB + i];
         end
         gpio_oe_b <= ~pin_direction_control[OUT_EN_LSB +: NUM_PINS];
         gpio_pulldown <= pin_direction_control[IN_EN_LSB +: NUM_PINS];
      end
   end

   // Self-test error flag and counter; a new error beats a clear in the same cycle
   assign st_err_event = bc_done && self_test_active && !crc_ok;
   assign st_clear = wr_en && (wr_addr == REG_ERR_CLEAR) && wr_data[ST_CLR_BIT];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         self_test_err <= 1'b0;
         self_test_error_count <= 8'h00;
      end else if (st_err_event) begin
         self_test_err <= 1'b1;
         if (st_clear) begin
            self_test_error_count <= 8'h01;
         end else if (self_test_error_count != 8'hFF) begin
            self_test_error_count <= self_test_error_count + 8'h01;
         end
      end else if (st_clear) begin
         self_test_err <= 1'b0;
         self_test_error_count <= 8'h00;
      end
   end

   // Forward frame timing and pin sampling period
   assign pin_count = (forwarded_pin_config[2:0] > 3'd4) ? 3'd4 : forwarded_pin_config[2:0];
   assign fc_period = (pin_count <= 3'd1) ? 3'd1 : (pin_count == 3'd2) ? 3'd2 : 3'd5;
   assign fwd_mask = 4'((5'h1 << pin_count) - 5'h1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fc_tick_cnt <= 4'd0;
         fc_tick <= 1'b0;
      end else begin
         fc_tick <= 1'b0;
         if (fc_tick_cnt == FC_FRAME_CYC - 4'd1) begin
            fc_tick_cnt <= 4'd0;
            fc_tick <= 1'b1;
         end else begin
            fc_tick_cnt <= fc_tick_cnt + 4'd1;
         end
      end
   end

   // Pins between samples keep their last value, which adds up to one period of jitter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fc_mod_cnt <= 3'd0;
         fwd_pins <= 4'h0;
      end else if (fc_tick) begin
         if (fc_mod_cnt >= fc_period - 3'd1) begin
            fc_mod_cnt <= 3'd0;
         end else begin
            fc_mod_cnt <= fc_mod_cnt + 3'd1;
         end
         if (fc_mod_cnt == 3'd0) begin
            fwd_pins <= gpio_s & fwd_mask;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prbs <= PRBS_SEED;
      end else if (fc_tick && self_test_active) begin
         prbs <= {prbs[21:0], prbs[22] ^ prbs[17]};
      end
   end

   always_comb begin
      next_body.self_test = self_test_active;
      next_body.pin_data = fwd_pins;
      next_body.pin_count = pin_count;
      next_body.payload = self_test_active ? prbs[20:0] : 21'h0;
      next_body.crc = crc8({3'h0, self_test_active, fwd_pins, pin_count, next_body.payload});
   end

   // Heavy bodies go out inverted to keep the line DC balanced
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fc_frame <= '0;
         fc_frame_valid <= 1'b0;
      end else begin
         fc_frame_valid <= fc_tick;
         if (fc_tick) begin
            fc_frame.sync <= FC_SYNC_WORD;
            if (count_ones(next_body) > FC_BALANCE_LIMIT) begin
               fc_frame.invert <= 1'b1;
               fc_frame.body <= ~next_body;
            end else begin
               fc_frame.invert <= 1'b0;
               fc_frame.body <= next_body;
            end
         end
      end
   end
endmodule // serializer_link_gpio
`default_nettype wire

// *** verilog/serializer_link_gpio_pkg.sv ***
`default_nettype none
package serializer_link_gpio_pkg;
   // Control bus register offsets
   localparam logic [7:0] REG_LOCAL_OUT = 8'h0D;
   localparam logic [7:0] REG_PIN_DIR = 8'h0E;
   localparam logic [7:0] REG_FWD_CFG = 8'h33;
   localparam logic [7:0] REG_ERR_CLEAR = 8'h49;
   localparam logic [7:0] REG_LINK_STS = 8'h52;
   localparam logic [7:0] REG_PIN_STS = 8'h53;
   localparam logic [7:0] REG_ST_ERR_CNT = 8'h54;
   // Reset values and field positions
   localparam logic [7:0] LOCAL_OUT_RESET = 8'h00;
   localparam logic [7:0] PIN_DIR_RESET = 8'h0F;
   localparam logic [7:0] FWD_CFG_RESET = 8'h00;
   localparam int IN_EN_LSB = 0;
   localparam int OUT_EN_LSB = 4;
   localparam int LOCAL_VAL_LSB = 0;
   localparam int REMOTE_SEL_LSB = 4;
   localparam int ST_ERR_BIT = 3;
   localparam int ST_CLR_BIT = 5;
   // Arbitrary control bus address
   localparam logic [6:0] DEVICE_ADDR = 7'h2A;
   localparam int NUM_PINS = 4;
   localparam logic [4:0] BC_LAST_BIT = 5'd29;
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int BC_SAMPLE_SYNC_KHZ_X10 = 16700;
   localparam int BC_SAMPLE_NONSYNC_KHZ_X10 = 3340;
   localparam int BC_SAMPLE_PARALLEL_KHZ_X10 = 835;
   localparam logic [8:0] BC_SAMPLE_SYNC_CYC = 9'(CLK_HZ / (BC_SAMPLE_SYNC_KHZ_X10 * 100));
   localparam logic [8:0] BC_SAMPLE_NONSYNC_CYC = 9'(CLK_HZ / (BC_SAMPLE_NONSYNC_KHZ_X10 * 100));
   localparam logic [8:0] BC_SAMPLE_PARALLEL_CYC = 9'(CLK_HZ / (BC_SAMPLE_PARALLEL_KHZ_X10 * 100));
   localparam logic [3:0] FC_FRAME_CYC = 4'd4;
   localparam logic [1:0] FC_SYNC_WORD = 2'h1;
   localparam logic [5:0] FC_BALANCE_LIMIT = 6'd18;
   localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;

   typedef enum logic [1:0] {MODE_SYNC, MODE_NONSYNC, MODE_PARALLEL} clk_mode_t;

   typedef struct packed {
      logic [3:0] pin_data;
      logic self_test_en;
      logic [16:0] control;
      logic [7:0] crc;
   } bc_frame_t;

   typedef struct packed {
      logic self_test;
      logic [3:0] pin_data;
      logic [2:0] pin_count;
      logic [20:0] payload;
      logic [7:0] crc;
   } fc_body_t;

   typedef struct packed {
      logic [1:0] sync;
      logic invert;
      fc_body_t body;
   } fc_frame_t;

   // CRC-8, polynomial x^8+x^2+x+1, MSB first
   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction
endpackage
`default_nettype wire
